// File: bench/rioc_fe.sv
// behavioural residual measurement front end feeding the trip block
`timescale 1ns/10ps
module rioc_fe
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_go,
   input  wire logic [15:0] i_pk,
   input  wire logic [15:0] i_rm,
   output logic [15:0]      o_peak,
   output logic [15:0]      o_rms,
   output logic             o_upd
);
   // both measures land together with the update strobe
   always_ff @(posedge i_sys_clk)
   begin
      o_upd  <= i_go;
      o_peak <= i_pk;
      o_rms  <= i_rm;
   end
endmodule

// File: bench/tb_residual_instant_overcurrent_trip.sv
// self-checking bench of the residual instantaneous trip
`timescale 1ns/10ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin \
   err_total++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_residual_instant_overcurrent_trip;
   import rioc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        we = 1'b0;
   logic        ext = 1'b0;
   logic        dbl = 1'b0;
   logic        blk = 1'b0;
   logic        go = 1'b0;
   logic [11:0] pct = 12'h000;
   logic [15:0] pk = 16'h0000;
   logic [15:0] rm = 16'h0000;
   rioc_op_t    op = RIOC_OP_OFF;
   logic [15:0] fpk, frm;
   logic        upd, it, gt, eon, eoff;
   logic [11:0] spct;
   rioc_op_t    opr;
   int          err_total = 0;
   int          checks_done = 0;
   int          n_on = 0;
   int          n_off = 0;
   always #25 clk = ~clk;
   // counts event pulses, each stands for one cycle only
   always @(posedge clk)
   begin
      if (eon === 1'b1)
         n_on++;
      if (eoff === 1'b1)
         n_off++;
   end
   rioc_fe fe (.i_sys_clk(clk), .i_go(go), .i_pk(pk), .i_rm(rm),
      .o_peak(fpk), .o_rms(frm), .o_upd(upd));
   rioc_trip uut (.i_sys_clk(clk), .i_rst(rst), .i_operation(op),
      .i_start_pct(pct), .i_start_pct_we(we), .i_ext_range(ext),
      .i_threshold_double_in(dbl), .i_function_block_in(blk),
      .i_residual_peak_value(fpk), .i_residual_fundamental_rms(frm),
      .i_meas_upd(upd), .o_internal_trip(it), .o_general_trip_out(gt),
      .o_event_on(eon), .o_event_off(eoff), .o_start_pct(spct),
      .o_operation(opr));
   ////////////////////////////////////////////////////////////////////
   task tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   // one measurement through the front end, then both trips judged
   task meas(input logic [15:0] p, r, input logic xi, xg);
      pk = p;
      rm = r;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(2);
      `CHK(it, xi)
      tick(1);
      `CHK(gt, xg)
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task t_peak;
      `CHK(spct, 12'h0C8)
      `CHK(opr, RIOC_OP_OFF)
      meas(16'hFFFF, 16'hFFFF, 1'b0, 1'b0);
      op = RIOC_OP_PEAK;
      meas(16'h0002, 16'hFFFF, 1'b0, 1'b0);
      meas(16'h0003, 16'h0000, 1'b1, 1'b1);
      `CHK(n_on, 1)
      `CHK(n_off, 0)
      meas(16'h0002, 16'h0000, 1'b0, 1'b0);
      `CHK(n_on, 1)
      `CHK(n_off, 1)
      $display("peak test done");
   endtask
   task t_fund;
      op = RIOC_OP_FUND;
      meas(16'hFFFF, 16'h0002, 1'b0, 1'b0);
      `CHK(opr, RIOC_OP_FUND)
      meas(16'h0000, 16'h0003, 1'b1, 1'b1);
      dbl = 1'b1;
      tick(3);
      meas(16'h0000, 16'h0004, 1'b0, 1'b0);
      meas(16'h0000, 16'h0005, 1'b1, 1'b1);
      dbl = 1'b0;
      blk = 1'b1;
      tick(3);
      meas(16'h0000, 16'h0009, 1'b1, 1'b0);
      `CHK(n_off, 3)
      blk = 1'b0;
      meas(16'h0000, 16'h0000, 1'b0, 1'b0);
      `CHK(n_on, 3)
      $display("fund double block test done");
   endtask
   task t_range;
      logic [11:0] wv[6];
      logic [11:0] ev[6];
      wv = '{12'h009, 12'h00A, 12'h3E9, 12'h3E8, 12'hBB8, 12'hBB9};
      ev = '{12'h0C8, 12'h00A, 12'h00A, 12'h3E8, 12'hBB8, 12'hBB8};
      for (int i = 0; i < 6; i++)
      begin
         ext = (i > 3);
         pct = wv[i];
         we = 1'b1;
         tick(1);
         we = 1'b0;
         tick(1);
         `CHK(spct, ev[i])
      end
      meas(16'h0000, 16'h001E, 1'b0, 1'b0);
      meas(16'h0000, 16'h001F, 1'b1, 1'b1);
      $display("range test done");
   endtask
   // reset in mid-run brings back the defaults, then the block trips again
   task t_reset;
      rst = 1'b1;
      tick(2);
      `CHK(spct, START_PCT_DEF)
      `CHK(opr, RIOC_OP_OFF)
      `CHK(it, 1'b0)
      `CHK(gt, 1'b0)
      rst = 1'b0;
      meas(16'h0000, 16'h0003, 1'b1, 1'b1);
      `CHK(n_on, 5)
      `CHK(n_off, 3)
      $display("reset test done");
   endtask
   initial
   begin
      tick(6);
      rst = 1'b0;
      tick(1);
      t_peak;
      t_fund;
      t_range;
      t_reset;
      stop_test;
   end
   initial
   begin
      #50000;
      err_total++;
      stop_test;
   end
endmodule

// File: design/rioc_cmp.sv
// combinational comparison of measure against threshold
`timescale 1ns/10ps
module rioc_cmp
   import rioc_pkg::*;
(
   rioc_meas_if.cmp m
);
   import rioc_pkg::*;
   logic [MEAS_W+PCT_W:0] scaled;
   // the measure is in units of rated current; compare meas*100 > pct
   assign scaled = (MEAS_W+PCT_W+1)'(m.meas) * (MEAS_W+PCT_W+1)'(PCT_FULL);
   // only a fresh measure counts, so a stale value never trips
   assign m.over = m.upd && (scaled > m.thresh);
endmodule

// File: design/rioc_meas_if.sv
// measurement carrier between the trip top and its comparator
`timescale 1ns/10ps
interface rioc_meas_if;
   import rioc_pkg::*;
   logic [MEAS_W-1:0] meas;
   logic [MEAS_W+PCT_W:0] thresh;
   logic              upd;
   logic              over;
   modport src (output meas, output thresh, output upd, input over);
   modport cmp (input meas, input thresh, input upd, output over);
endinterface

// File: design/rioc_pkg.sv
// constants and types of the residual instantaneous overcurrent trip
package rioc_pkg;
   localparam int unsigned MEAS_W          = 16;
   localparam int unsigned PCT_W           = 12;
   localparam logic [11:0] START_PCT_DEF   = 12'h0C8;
   localparam logic [11:0] START_PCT_MIN   = 12'h00A;
   localparam logic [11:0] START_PCT_MAX   = 12'h3E8;
   localparam logic [11:0] START_PCT_XMAX  = 12'hBB8;
   localparam logic [11:0] START_PCT_STEP  = 12'h001;
   localparam int unsigned PCT_FULL        = 100;
   typedef enum logic [1:0] {
      RIOC_OP_OFF,
      RIOC_OP_PEAK,
      RIOC_OP_FUND
   } rioc_op_t;
endpackage

// File: design/rioc_trip.sv
// residual instantaneous overcurrent trip decision and decision logic
//
// Behaviour
// - internal trip registers the comparison, one clock after the update.
// - operation is off, peak or fundamental, default off, off never trips.
// - start threshold is an integer percent, step one, default 200.
// - start threshold accepts 10 to 1000, or up to 3000 when extended.
// - while the doubling input is high the threshold used is twice the set.
// - while the block input is high the general trip stays low.
// - general trip is internal trip and enabled and not blocked.
// - each change of general trip outside reset emits an on or off event; reset clears it with none.
`timescale 1ns/10ps
module rioc_trip
   import rioc_pkg::*;
(
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   input  wire rioc_pkg::rioc_op_t  i_operation,
   input  wire logic [PCT_W-1:0]    i_start_pct,
   input  wire logic                i_start_pct_we,
   input  wire logic                i_ext_range,
   input  wire logic                i_threshold_double_in,
   input  wire logic                i_function_block_in,
   input  wire logic [MEAS_W-1:0]   i_residual_peak_value,
   input  wire logic [MEAS_W-1:0]   i_residual_fundamental_rms,
   input  wire logic                i_meas_upd,
   output logic                     o_internal_trip,
   output logic                     o_general_trip_out,
   output logic                     o_event_on,
   output logic                     o_event_off,
   output logic [PCT_W-1:0]         o_start_pct,
   output rioc_pkg::rioc_op_t       o_operation
);
   import rioc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers for user logic levels
   logic dbl_s1_r, dbl_r, blk_s1_r, blk_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         dbl_s1_r <= 1'b0;
         dbl_r    <= 1'b0;
         blk_s1_r <= 1'b0;
         blk_r    <= 1'b0;
      end
      else
      begin
         dbl_s1_r <= i_threshold_double_in;
         dbl_r    <= dbl_s1_r;
         blk_s1_r <= i_function_block_in;
         blk_r    <= blk_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // settings
   rioc_op_t         op_r;
   logic [PCT_W-1:0] pct_r;
   logic             pct_ok;
   // out of range writes are ignored
   assign pct_ok = (i_start_pct >= START_PCT_MIN) &&
      (i_start_pct <= (i_ext_range ? START_PCT_XMAX : START_PCT_MAX));
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         pct_r <= START_PCT_DEF;
      else if (i_start_pct_we && pct_ok)
         pct_r <= i_start_pct;
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         op_r <= RIOC_OP_OFF;
      else
         op_r <= i_operation;
   end
   assign o_start_pct = pct_r;
   assign o_operation = op_r;

   ////////////////////////////////////////////////////////////////////////
   // comparison
   rioc_meas_if mif ();
   assign mif.meas = (op_r == RIOC_OP_PEAK) ? i_residual_peak_value
                                            : i_residual_fundamental_rms;
   assign mif.thresh = dbl_r ? {(MEAS_W)'(0), pct_r, 1'b0}
                             : {(MEAS_W+1)'(0), pct_r};
   assign mif.upd = i_meas_upd;
   rioc_cmp u_cmp (.m(mif));

   logic itrip_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         itrip_r <= 1'b0;
      else if (op_r == RIOC_OP_OFF)
         itrip_r <= 1'b0;
      else if (i_meas_upd)
         itrip_r <= mif.over;
   end
   assign o_internal_trip = itrip_r;

   ////////////////////////////////////////////////////////////////////////
   // decision logic and events
   logic gen_r, ev_on_r, ev_off_r, gen_nxt;
   assign gen_nxt = itrip_r && (op_r != RIOC_OP_OFF) && !blk_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         gen_r <= 1'b0;
      else
         gen_r <= gen_nxt;
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         ev_on_r  <= 1'b0;
         ev_off_r <= 1'b0;
      end
      else
      begin
         ev_on_r  <= gen_nxt && !gen_r;
         ev_off_r <= !gen_nxt && gen_r;
      end
   end
   assign o_general_trip_out = gen_r;
   assign o_event_on         = ev_on_r;
   assign o_event_off        = ev_off_r;

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_trip_needs_enable: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_general_trip_out |->
      $past(itrip_r) && !$past(blk_r) && $past(op_r) != RIOC_OP_OFF)
      else $error("general trip without its causes");
   chk_block_holds_low: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) blk_r |=> !o_general_trip_out)
      else $error("general trip while blocked");
   chk_off_no_trip: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) op_r == RIOC_OP_OFF |=> !o_internal_trip)
      else $error("internal trip while off");
   chk_trip_immediate: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && mif.over && op_r != RIOC_OP_OFF)
      |=> o_internal_trip)
      else $error("internal trip late");
   chk_trip_drops: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && !mif.over) |=> !o_internal_trip)
      else $error("internal trip did not drop");
   chk_event_on: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) $rose(o_general_trip_out) |-> o_event_on)
      else $error("missing on event");
   chk_event_off: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) $fell(o_general_trip_out) |-> o_event_off)
      else $error("missing off event");
   // the measure is scaled by a hundred to meet the percent setting
   chk_double_thresh: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && dbl_r &&
      32'(mif.meas) * PCT_FULL <= 32'(pct_r) * 2) |=> !o_internal_trip)
      else $error("threshold not doubled");
   chk_pct_range: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) pct_r >= START_PCT_MIN && pct_r <= START_PCT_XMAX)
      else $error("start setting out of range");

   ////////////////////////////////////////////////////////////////////////
   // behaviour checks independent of the comparator
   chk_double_trips: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && dbl_r && op_r != RIOC_OP_OFF &&
      32'(mif.meas) * PCT_FULL > 32'(pct_r) * 2) |=> o_internal_trip)
      else $error("doubled threshold not tripped");
   chk_single_trips: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && !dbl_r && op_r != RIOC_OP_OFF &&
      32'(mif.meas) * PCT_FULL > 32'(pct_r)) |=> o_internal_trip)
      else $error("measure over threshold not tripped");
   chk_single_holds: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_meas_upd && !dbl_r &&
      32'(mif.meas) * PCT_FULL <= 32'(pct_r)) |=> !o_internal_trip)
      else $error("measure at threshold tripped");
   chk_trip_holds: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (!i_meas_upd && op_r != RIOC_OP_OFF)
      |=> $stable(o_internal_trip))
      else $error("internal trip moved without update");
   chk_peak_source: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) op_r == RIOC_OP_PEAK
      |-> mif.meas == i_residual_peak_value)
      else $error("peak mode compares the wrong measure");
   chk_fund_source: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) op_r == RIOC_OP_FUND
      |-> mif.meas == i_residual_fundamental_rms)
      else $error("fundamental mode compares the wrong measure");
   chk_gen_follows: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (o_internal_trip && op_r != RIOC_OP_OFF && !blk_r)
      |=> o_general_trip_out)
      else $error("general trip missing");
   chk_event_on_src: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_event_on |-> $rose(o_general_trip_out))
      else $error("on event without a rise");
   chk_event_off_src: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) o_event_off |-> $fell(o_general_trip_out))
      else $error("off event without a fall");
   chk_event_onehot: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) !(o_event_on && o_event_off))
      else $error("on and off events together");
   chk_op_follows: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) 1'b1 |=> o_operation == $past(i_operation))
      else $error("operation setting not taken");
   chk_pct_hold: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) !i_start_pct_we |=> $stable(o_start_pct))
      else $error("start setting moved without a write");
   chk_pct_refused: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_start_pct_we && (i_start_pct < START_PCT_MIN ||
      i_start_pct > (i_ext_range ? START_PCT_XMAX : START_PCT_MAX)))
      |=> $stable(o_start_pct))
      else $error("out of range start setting taken");
   chk_pct_loaded: assert property (@(posedge i_sys_clk)
      disable iff (i_rst) (i_start_pct_we && i_start_pct >= START_PCT_MIN &&
      i_start_pct <= (i_ext_range ? START_PCT_XMAX : START_PCT_MAX))
      |=> o_start_pct == $past(i_start_pct))
      else $error("start setting not taken");
endmodule
